// [logic/ddc_fifo.sv]
`timescale 1ns/100ps

// Small FIFO; the head word is presented from a register.
module ddc_fifo
  import ddc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];  // Word store.
  logic [AW-1:0] wptr_q;  // Next write slot.
  logic [AW-1:0] rptr_q;  // Next read slot.
  logic [AW:0] cnt_q;  // Words in the store, not counting the head.
  logic head_valid_q;  // Head register holds a word.
  logic [WIDTH-1:0] head_q;  // Head word.
  logic push;
  logic pull;

  // Ready while the store has a free slot; the head register is extra.
  assign in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = head_valid_q;
  assign out_data = head_q;
  assign push = in_valid && in_ready;
  // Refill the head when it is empty or being taken this cycle.
  assign pull = (cnt_q != '0) && (!head_valid_q || out_ready);

  // ----------------------------------------------------------------------
  // Pointer, count and head update
  // ----------------------------------------------------------------------
  // The store is written without reset; only control state is cleared.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wptr_q] <= in_data;
    end
    if (pull)
    begin
      head_q <= mem_q[rptr_q];
    end
  end

  // Control state follows the usual full/empty bookkeeping.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      head_valid_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pull)
      begin
        rptr_q <= rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pull);
      if (pull)
      begin
        head_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        head_valid_q <= 1'b0;
      end
    end
  end

endmodule

// [logic/ddc_pkg.sv]
package ddc_pkg;

  // ----------------------------------------------------------------------
  // Serial command framing
  // ----------------------------------------------------------------------
  // Data bits per command word; the seventeenth bit is parity.
  localparam logic [4:0] DDC_DATA_BITS = 5'h10;
  // Bit count reset value.
  localparam logic [4:0] DDC_CNT_RST = 5'h00;

  // ----------------------------------------------------------------------
  // Command word fields, held in the upper data register
  // ----------------------------------------------------------------------
  localparam int DDC_FN_HI = 7;
  localparam int DDC_FN_LO = 4;
  localparam int DDC_MOD_HI = 3;
  localparam int DDC_MOD_LO = 0;
  // Control function and its reset modifier.
  localparam logic [3:0] DDC_FN_CONTROL = 4'h5;
  localparam logic [3:0] DDC_MOD_RESET = 4'h0;
  // Functions that return a reply word to the controller.
  localparam logic [3:0] DDC_FN_REQ_STATUS = 4'h2;
  localparam logic [3:0] DDC_FN_REQ_CONFIG = 4'h3;

  // ----------------------------------------------------------------------
  // Microcontroller register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] DDC_ADDR_UPPER = 2'h0;
  localparam logic [1:0] DDC_ADDR_LOWER = 2'h1;
  localparam logic [1:0] DDC_ADDR_FAULT = 2'h2;
  localparam logic [1:0] DDC_ADDR_DONE = 2'h3;
  // Fault register bit positions.
  localparam int DDC_FLT_PARITY = 0;
  localparam int DDC_FLT_HANDSHAKE = 4;
  localparam int DDC_FLT_WRITE = 7;
  // Value that must be written to signal completion.
  localparam logic [7:0] DDC_DONE_VALUE = 8'h00;

  // ----------------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------------
  localparam int DDC_FIFO_WIDTH = 16;
  localparam int DDC_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Asynchronous pins from the controller cable and the drive board.
  typedef struct packed {
    logic [2:0] drive_select;
    logic [2:0] drive_id_strap;
    logic read_gate_request;
    logic write_gate_request;
    logic write_protect;
    logic transfer_req;
    logic serial_command_bit;
    logic external_error_pin;
  } ddc_pins_t;

  // Microcontroller register request.
  typedef struct packed {
    logic [1:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ddc_mc_req_t;

  // Handshake phase of the serial port.
  typedef enum logic [1:0] {
    DDC_ST_IDLE,
    DDC_ST_ACK,
    DDC_ST_PUSH
  } ddc_phase_t;

endpackage

// [logic/ddc_port.sv]
// Notes on behaviour
// - Code zero selects none; one..seven select.
// - Selected when code equals strap; only then commands.
// - Read gate follows; write gate follows normally.
// - Write protect holds write gate low.
// - Both gates while selected sets write fault.
// - Command is sixteen bits then parity.
// - Request marks valid bit; acknowledge after sampling.
// - Each selected request steps seventeen-state counter.
// - Count halts at sixteen or on capture.
// - Reply mode clears capture, re-enables counter.
// - Attention from four fault sources.
// - Write fault clears on control reset command.
// - Parity input: command bit or upper MSB.
// - Odd parity; inverted is fault; else appended.
// - Good parity raises command-ready interrupt.
// - Parity steps per bit; cleared on interrupt/fault.
// - Selection dropped mid-word: handshake fault.
// - Two-bit address picks four registers.
// - Fault register bits 0, 4, 7; read-only.
// - Reply bytes plus parity shifted, then complete.
// - Zero write to done register signals complete.
// - Upper register high byte, lower register low.
`timescale 1ns/100ps

module ddc_port
  import ddc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ddc_pins_t pins_i,
  input wire ddc_mc_req_t mc_req,
  output logic [7:0] mc_rdata,
  output logic cmd_ready_int,
  output logic unit_selected,
  output logic read_gate_out,
  output logic write_gate_out,
  output logic transfer_ack,
  output logic reply_data,
  output logic command_complete,
  output logic attention
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Every flip-flop of the port outside the command queue lives in this one record.
  typedef struct packed {
    ddc_pins_t s1;  // First synchroniser stage, read only by s2.
    ddc_pins_t s2;  // Second synchroniser stage.
    logic treq_prev;  // Request level one cycle ago, for edge detect.
    logic sel;  // Unit selected.
    logic rg_out;  // Read gate to the channel.
    logic wg_out;  // Write gate to the channel.
    logic tack;  // Transfer acknowledge.
    logic reply_bit;  // Config/status data line.
    ddc_phase_t ph;  // Handshake phase.
    logic [4:0] cnt;  // Bits moved in the current word.
    logic captured;  // All seventeen bits received.
    logic reply;  // Reply shift mode.
    logic in_prog;  // Transfer in progress.
    logic par;  // Running odd parity.
    logic [15:0] shreg;  // Receive shift register.
    logic [7:0] reg_a;  // Upper command byte.
    logic [7:0] reg_b;  // Lower command byte.
    logic holding;  // A command is in the registers.
    logic req_data;  // Held command wants a reply.
    logic int_q;  // Command-ready interrupt.
    logic wr_flt;  // Write conflict fault.
    logic par_flt;  // Parity fault.
    logic hs_flt;  // Handshake fault.
    logic done;  // Command complete.
    logic atten;  // Attention.
    logic [7:0] rdata;  // Read data to the microcontroller.
  } ddc_state_t;

  ddc_state_t q;  // Registered state.
  ddc_state_t d;  // Next state.

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // True when an upper byte names a command that returns data.
  function automatic logic wants_reply(input logic [7:0] upper);
    logic [3:0] fn;
    fn = upper[DDC_FN_HI:DDC_FN_LO];
    return (fn == DDC_FN_REQ_STATUS) || (fn == DDC_FN_REQ_CONFIG);
  endfunction

  // True when an upper byte is the control reset command.
  function automatic logic is_reset_cmd(input logic [7:0] upper);
    return (upper[DDC_FN_HI:DDC_FN_LO] == DDC_FN_CONTROL) &&
           (upper[DDC_MOD_HI:DDC_MOD_LO] == DDC_MOD_RESET);
  endfunction

  // ----------------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------------
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;

  // The head is taken only when the registers are free.
  assign fifo_out_ready = !q.holding;

  ddc_fifo #(
    .WIDTH(DDC_FIFO_WIDTH),
    .DEPTH(DDC_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(q.shreg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Clears are applied before sets so that a fault raised in the same
  // cycle as its clear survives.
  always_comb
  begin
    logic step;
    logic sel_now;
    logic par_fin;
    // Locals start from a known value so no path leaves them latched.
    step = 1'b0;
    sel_now = 1'b0;
    par_fin = 1'b0;
    d = q;
    fifo_in_valid = 1'b0;

    // Two stages on every cable and board pin.
    d.s1 = pins_i;
    d.s2 = q.s1;
    d.treq_prev = q.s2.transfer_req;

    // Code zero never matches, so no drive answers it.
    sel_now = (q.s2.drive_select == q.s2.drive_id_strap) &&
              (q.s2.drive_select != 3'h0);
    d.sel = sel_now;

    // Gates pass through; protect overrides the write gate.
    d.rg_out = q.s2.read_gate_request;
    d.wg_out = q.s2.write_gate_request &&
               !q.s2.write_protect;

    // Microcontroller reads; reading faults clears the soft faults.
    if (mc_req.rd)
    begin
      case (mc_req.addr)
        DDC_ADDR_UPPER: d.rdata = q.reg_a;
        DDC_ADDR_LOWER:
        begin
          d.rdata = q.reg_b;
          d.int_q = 1'b0;
        end
        DDC_ADDR_FAULT:
        begin
          d.rdata = 8'h00;
          d.rdata[DDC_FLT_PARITY] = q.par_flt;
          d.rdata[DDC_FLT_HANDSHAKE] = q.hs_flt;
          d.rdata[DDC_FLT_WRITE] = q.wr_flt;
          d.par_flt = 1'b0;
          d.hs_flt = 1'b0;
        end
        default: d.rdata = 8'h00;
      endcase
    end

    // Microcontroller writes; the fault register ignores them.
    if (mc_req.wr && q.holding && !q.reply)
    begin
      case (mc_req.addr)
        DDC_ADDR_UPPER: d.reg_a = mc_req.wdata;
        DDC_ADDR_LOWER:
        begin
          d.reg_b = mc_req.wdata;
          // The lower byte completes the reload and starts the reply.
          if (q.req_data)
          begin
            d.reply = 1'b1;
            d.captured = 1'b0;
            d.cnt = DDC_CNT_RST;
            d.par = 1'b0;
          end
        end
        DDC_ADDR_DONE:
        begin
          if (mc_req.wdata == DDC_DONE_VALUE && !q.req_data)
          begin
            d.done = 1'b1;
            d.holding = 1'b0;
            d.int_q = 1'b0;
          end
        end
        default: d.reply = q.reply;
      endcase
    end

    // Load the next queued command into the byte registers.
    if (fifo_out_valid && !q.holding)
    begin
      d.reg_a = fifo_out_data[15:8];
      d.reg_b = fifo_out_data[7:0];
      d.holding = 1'b1;
      d.req_data = wants_reply(fifo_out_data[15:8]);
      d.int_q = 1'b1;
      if (is_reset_cmd(fifo_out_data[15:8]))
      begin
        d.wr_flt = 1'b0;
      end
    end

    // Both gates on a selected drive is a write conflict.
    if (q.sel && q.s2.read_gate_request && q.s2.write_gate_request)
    begin
      d.wr_flt = 1'b1;
    end

    // One step per rising request while selected and idle.
    step = q.sel && q.s2.transfer_req && !q.treq_prev &&
           (q.ph == DDC_ST_IDLE);

    case (q.ph)
      DDC_ST_IDLE:
      begin
        if (step && q.reply)
        begin
          if (q.cnt != DDC_DATA_BITS)
          begin
            // Data bits leave from the upper MSB.
            d.reply_bit = q.reg_a[7];
            d.par = q.par ^ q.reg_a[7];
            {d.reg_a, d.reg_b} = {q.reg_a[6:0], q.reg_b, 1'b0};
            d.cnt = q.cnt + 5'h01;
            d.in_prog = 1'b1;
          end
          else
          begin
            // Seventeenth bit is the generated odd parity.
            d.reply_bit = ~q.par;
            d.cnt = DDC_CNT_RST;
            d.par = 1'b0;
            d.reply = 1'b0;
            d.in_prog = 1'b0;
            d.holding = 1'b0;
            d.int_q = 1'b0;
            d.done = 1'b1;
          end
          d.tack = 1'b1;
          d.ph = DDC_ST_ACK;
        end
        else if (step && !q.captured)
        begin
          if (q.cnt != DDC_DATA_BITS)
          begin
            d.shreg = {q.shreg[14:0], q.s2.serial_command_bit};
            d.par = q.par ^ q.s2.serial_command_bit;
            d.cnt = q.cnt + 5'h01;
            d.in_prog = 1'b1;
            // A completion newly written this cycle survives; one already set is cleared.
            d.done = d.done && !q.done;
            d.tack = 1'b1;
            d.ph = DDC_ST_ACK;
          end
          else
          begin
            // Parity bit closes the word and halts the counter.
            par_fin = q.par ^ q.s2.serial_command_bit;
            d.captured = 1'b1;
            d.in_prog = 1'b0;
            d.par = 1'b0;
            if (par_fin)
            begin
              d.ph = DDC_ST_PUSH;
            end
            else
            begin
              d.par_flt = 1'b1;
              d.captured = 1'b0;
              d.cnt = DDC_CNT_RST;
              d.tack = 1'b1;
              d.ph = DDC_ST_ACK;
            end
          end
        end
      end
      DDC_ST_ACK:
      begin
        // Acknowledge stands until the request is withdrawn.
        if (!q.s2.transfer_req)
        begin
          d.tack = 1'b0;
          d.ph = DDC_ST_IDLE;
        end
      end
      DDC_ST_PUSH:
      begin
        // A full queue withholds the last acknowledge, stalling the
        // controller instead of dropping a command.
        fifo_in_valid = 1'b1;
        if (fifo_in_ready)
        begin
          d.captured = 1'b0;
          d.cnt = DDC_CNT_RST;
          d.tack = 1'b1;
          d.ph = DDC_ST_ACK;
        end
      end
      default: d.ph = DDC_ST_IDLE;
    endcase

    // Losing selection mid-word aborts it and flags the interface.
    if (q.sel && !sel_now && (q.in_prog || q.ph == DDC_ST_PUSH))
    begin
      d.hs_flt = 1'b1;
      d.in_prog = 1'b0;
      d.par = 1'b0;
      d.cnt = DDC_CNT_RST;
      d.captured = 1'b0;
      d.reply = 1'b0;
      d.tack = 1'b0;
      d.ph = DDC_ST_IDLE;
    end

    d.atten = d.wr_flt || d.par_flt || d.hs_flt ||
              q.s2.external_error_pin;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronous reset clears all state to its idle value.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign mc_rdata = q.rdata;
  assign cmd_ready_int = q.int_q;
  assign unit_selected = q.sel;
  assign read_gate_out = q.rg_out;
  assign write_gate_out = q.wg_out;
  assign transfer_ack = q.tack;
  assign reply_data = q.reply_bit;
  assign command_complete = q.done;
  assign attention = q.atten;

endmodule

// [testbench/ddc_ctrl_model.sv]
`timescale 1ns/100ps

// Controller end of the serial command line.
module ddc_ctrl_model
(
  input wire logic clk,
  input wire logic transfer_ack,
  input wire logic reply_data,
  output logic transfer_req,
  output logic cmd_bit
);
  initial
  begin
    transfer_req = 1'b0;
    cmd_bit = 1'b1;
  end
  // Moves n bits, first bit from w[16]; gap idles between bits.
  // A bit that is never acknowledged clears ok but is not retried.
  task automatic xfer(input logic [16:0] w, input int n, input int gap,
    output logic [16:0] r, output logic ok);
    int i;
    int k;
    r = 17'h0;
    ok = 1'b1;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      cmd_bit <= w[16 - i];
      transfer_req <= 1'b1;
      k = 0;
      while (transfer_ack !== 1'b1 && k < 60)
      begin
        @(posedge clk);
        k++;
      end
      ok &= (transfer_ack === 1'b1);
      r[16 - i] = reply_data;
      // Once released the line shows the inverse, never a stale bit.
      transfer_req <= 1'b0;
      cmd_bit <= ~w[16 - i];
      while (transfer_ack !== 1'b0 && k < 120)
      begin
        @(posedge clk);
        k++;
      end
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

// [testbench/ddc_port_assertions.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module ddc_port_checker
  import ddc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ddc_pins_t pins_i,
  input wire ddc_mc_req_t mc_req,
  input wire logic [7:0] mc_rdata,
  input wire logic cmd_ready_int,
  input wire logic unit_selected,
  input wire logic read_gate_out,
  input wire logic write_gate_out,
  input wire logic transfer_ack,
  input wire logic reply_data,
  input wire logic command_complete,
  input wire logic attention
);
  // Cycles since reset; the pin synchronisers need time to fill.
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic warm;
  // Saturating count so that it never wraps back to cold.
  always_comb
  begin
    up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    up_q <= rst ? 4'h0 : up_d;
  end
  assign warm = up_q > 4'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_sel;
    (warm && $stable({pins_i.drive_select, pins_i.drive_id_strap}))[*6]
      |-> unit_selected == (pins_i.drive_select == pins_i.drive_id_strap
      && pins_i.drive_select != 3'h0);
  endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_rg;
    (warm && $stable(pins_i.read_gate_request))[*6]
      |-> read_gate_out == pins_i.read_gate_request;
  endproperty
  a_rg: assert property (p_rg) else $error("read gate wrong");
  property p_wg;
    (warm && pins_i.write_gate_request && !pins_i.write_protect
      && !pins_i.read_gate_request)[*6] |-> write_gate_out;
  endproperty
  a_wg: assert property (p_wg) else $error("write gate low");
  property p_wp;
    (warm && pins_i.write_protect)[*6] |-> !write_gate_out;
  endproperty
  a_wp: assert property (p_wp) else $error("protect ignored");
  property p_ext;
    (warm && pins_i.external_error_pin)[*6] |-> attention;
  endproperty
  a_ext: assert property (p_ext) else $error("no attention");
  property p_write_conflict_fault;
    (warm && pins_i.read_gate_request && pins_i.write_gate_request
      && unit_selected)[*4] |-> ##[0:4] attention;
  endproperty
  a_write_conflict_fault: assert property (p_write_conflict_fault) else $error("conflict missed");
  property p_ack_sel;
    $rose(transfer_ack) |-> $past(unit_selected);
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack unselected");
  property p_ack_rel;
    (!pins_i.transfer_req)[*6] |-> !transfer_ack;
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack held");
  property p_rd_hold;
    !mc_req.rd |=> $stable(mc_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_flt_rsv;
    mc_req.rd && mc_req.addr == DDC_ADDR_FAULT
      |=> (mc_rdata & 8'h6e) == 8'h00;
  endproperty
  a_flt_rsv: assert property (p_flt_rsv) else $error("unused bit set");
  property p_done_rd;
    mc_req.rd && mc_req.addr == DDC_ADDR_DONE |=> mc_rdata == 8'h00;
  endproperty
  a_done_rd: assert property (p_done_rd) else $error("done readable");
  c_ready: cover property ($rose(cmd_ready_int));
  c_done: cover property ($rose(command_complete));
  c_att: cover property ($rose(attention));
endmodule

bind ddc_port ddc_port_checker chk_u (
  .clk(clk), .rst(rst), .pins_i(pins_i), .mc_req(mc_req),
  .mc_rdata(mc_rdata), .cmd_ready_int(cmd_ready_int),
  .unit_selected(unit_selected), .read_gate_out(read_gate_out),
  .write_gate_out(write_gate_out), .transfer_ack(transfer_ack),
  .reply_data(reply_data), .command_complete(command_complete),
  .attention(attention)
);

// [testbench/tb_ddc_port.sv]
`timescale 1ns/100ps

module tb_ddc_port
  import ddc_pkg::*;
;
  logic clk;
  logic rst;
  logic [2:0] dsel;
  logic rg, wg, wp, ext, treq, cbit;
  ddc_pins_t pins;
  ddc_mc_req_t mc;
  logic [7:0] rdata;
  logic rdy, sel, rgo, wgo, ack, rbit, cc, att;
  int n_mismatch = 0;
  int num_checks = 0;
  // The strap is the only tied input; this drive answers to code 3.
  assign pins = {dsel, 3'h3, rg, wg, wp, treq, cbit, ext};
  ddc_port dut_u (.clk(clk), .rst(rst), .pins_i(pins), .mc_req(mc),
    .mc_rdata(rdata), .cmd_ready_int(rdy), .unit_selected(sel),
    .read_gate_out(rgo), .write_gate_out(wgo), .transfer_ack(ack),
    .reply_data(rbit), .command_complete(cc), .attention(att));
  ddc_ctrl_model ctrl_u (.clk(clk), .transfer_ack(ack),
    .reply_data(rbit), .transfer_req(treq), .cmd_bit(cbit));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Long enough for two synchroniser stages plus the output flop.
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic mc_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    mc <= '{a, 1'b0, 1'b1, d};
    @(posedge clk);
    mc.wr <= 1'b0;
  endtask
  // Read data is registered, so it is sampled one edge after the take.
  task automatic reg_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    mc <= '{a, 1'b1, 1'b0, 8'h00};
    @(posedge clk);
    mc.rd <= 1'b0;
    @(posedge clk);
    chk(17'(rdata), 17'(exp));
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 80)
    begin
      @(posedge clk);
      k++;
    end
    chk(17'(rdy), 17'h1);
  endtask
  // Sends one word with odd parity, or with it spoiled.
  task automatic send(input logic [15:0] w, input logic good, input int gap);
    logic [16:0] r;
    logic ok;
    ctrl_u.xfer({w, ~^w ^ ~good}, 17, gap, r, ok);
    chk(17'(ok), 17'h1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk({12'h0, att, cc, rdy, ack, sel}, 17'h0);
    reg_chk(DDC_ADDR_DONE, 8'h00);
    mc_wr(DDC_ADDR_FAULT, 8'hff);
    reg_chk(DDC_ADDR_FAULT, 8'h00);
  endtask
  task automatic t_gates();
    int i;
    rg <= 1'b1;
    settle();
    chk(17'(rgo), 17'h1);
    rg <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      {wg, wp} <= i[1:0];
      settle();
      chk(17'(wgo), 17'(i == 2));
    end
    ext <= 1'b1;
    wp <= 1'b0;
    settle();
    chk(17'(att), 17'h1);
    ext <= 1'b0;
    {rg, wg} <= 2'h3;
    settle();
    {rg, wg} <= 2'h0;
    reg_chk(DDC_ADDR_FAULT, 8'h80);
    send(16'h5000, 1'b1, 0);
    wait_rdy();
    reg_chk(DDC_ADDR_UPPER, 8'h50);
    reg_chk(DDC_ADDR_LOWER, 8'h00);
    reg_chk(DDC_ADDR_FAULT, 8'h00);
    chk(17'(att), 17'h0);
    mc_wr(DDC_ADDR_DONE, DDC_DONE_VALUE);
    settle();
    chk(17'(cc), 17'h1);
  endtask
  // Two words back to back, the second sent slowly, both queued.
  task automatic t_cmd();
    send(16'ha5c3, 1'b1, 0);
    send(16'h0f0e, 1'b1, 5);
    wait_rdy();
    reg_chk(DDC_ADDR_UPPER, 8'ha5);
    reg_chk(DDC_ADDR_LOWER, 8'hc3);
    mc_wr(DDC_ADDR_DONE, DDC_DONE_VALUE);
    wait_rdy();
    reg_chk(DDC_ADDR_UPPER, 8'h0f);
    reg_chk(DDC_ADDR_LOWER, 8'h0e);
    mc_wr(DDC_ADDR_DONE, DDC_DONE_VALUE);
    settle();
    chk(17'(rdy), 17'h0);
  endtask
  task automatic t_parity();
    send(16'h1234, 1'b0, 0);
    settle();
    chk(17'(att), 17'h1);
    chk(17'(rdy), 17'h0);
    reg_chk(DDC_ADDR_FAULT, 8'h01);
    reg_chk(DDC_ADDR_FAULT, 8'h00);
    send(16'h8001, 1'b1, 0);
    wait_rdy();
    reg_chk(DDC_ADDR_UPPER, 8'h80);
    reg_chk(DDC_ADDR_LOWER, 8'h01);
    mc_wr(DDC_ADDR_DONE, DDC_DONE_VALUE);
  endtask
  // Status then configuration request, each answered with a reply word.
  task automatic t_reply();
    logic [15:0] w;
    logic [16:0] r;
    logic ok;
    int j;
    for (j = 0; j < 2; j++)
    begin
      w = 16'h963c ^ 16'(j);
      send({(j == 0) ? DDC_FN_REQ_STATUS : DDC_FN_REQ_CONFIG, 12'h000},
        1'b1, 0);
      wait_rdy();
      reg_chk(DDC_ADDR_LOWER, 8'h00);
      mc_wr(DDC_ADDR_UPPER, w[15:8]);
      mc_wr(DDC_ADDR_LOWER, w[7:0]);
      ctrl_u.xfer(17'h0, 17, 1, r, ok);
      chk(17'(ok), 17'h1);
      chk(r, {w, ~^w});
      settle();
      chk(17'(cc), 17'h1);
    end
  endtask
  // Refusal while unselected, then a word cut short by deselection.
  task automatic t_select();
    logic [16:0] r;
    logic ok;
    int i;
    for (i = 0; i < 2; i++)
    begin
      dsel <= (i == 0) ? 3'h0 : 3'h5;
      settle();
      chk(17'(sel), 17'h0);
      ctrl_u.xfer(17'h1ffff, 1, 0, r, ok);
      chk(17'(ok), 17'h0);
    end
    dsel <= 3'h3;
    settle();
    chk(17'(sel), 17'h1);
    ctrl_u.xfer(17'h1ffff, 5, 0, r, ok);
    dsel <= 3'h6;
    settle();
    dsel <= 3'h3;
    reg_chk(DDC_ADDR_FAULT, 8'h10);
    settle();
    send(16'h4321, 1'b1, 0);
    wait_rdy();
    reg_chk(DDC_ADDR_UPPER, 8'h43);
    reg_chk(DDC_ADDR_LOWER, 8'h21);
  endtask
  initial
  begin
    rst = 1'b1;
    dsel = 3'h3;
    {rg, wg, wp, ext} = 4'h0;
    mc = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    $display("reset test done");
    t_gates();
    $display("gates test done");
    t_cmd();
    $display("command test done");
    t_parity();
    $display("parity test done");
    t_reply();
    $display("reply test done");
    t_select();
    $display("select test done");
    complete_run();
  end
endmodule
